// file: logic/dssp_defs.vh
// Purpose: constants for the two-wire register-access slave port
// Assumes: included by the design files by bare name
// Notes: definitions only
`ifndef DSSP_DEFS_VH
`define DSSP_DEFS_VH

`define DSSP_ADDR_DEFAULT   7'h1c
`define DSSP_REG_DEV_ADDR   8'h0c
`define DSSP_REG_CONTROL    8'h02
`define DSSP_DIS_BIT        0
`define DSSP_ADDR_MSB       6
`define DSSP_BIT_LAST       3'h7
`define DSSP_DIR_READ       1'b1

`endif

// file: logic/dssp_addr_reg.v
// Purpose: device address holder for the two-wire slave
// Assumes: write strobe and data come from the clock domain of CLOCK
// Notes: holds the 7-bit address
`timescale 1ns/100ps
`include "dssp_defs.vh"

module dssp_addr_reg (
	clk,
	rst,
	wr_en,
	wr_data,
	addr
);
	input  wire       clk;
	input  wire       rst;
	input  wire       wr_en;
	input  wire [6:0] wr_data;
	output reg  [6:0] addr;

	// stands in for the non-volatile cell: reset restores the factory value
	always @(posedge clk) begin
		if (rst)
			addr <= `DSSP_ADDR_DEFAULT;
		else if (wr_en)
			addr <= wr_data;
	end
endmodule // dssp_addr_reg

// file: logic/dssp_two_wire_slave.v
// Purpose: two-wire slave port sharing its pins with the four-wire port
// Assumes: bus pins and select pin are asynchronous to CLOCK; CLOCK much faster than SCL
// Notes: register contents outside this block are reached through REG_* ports
`timescale 1ns/100ps
`include "dssp_defs.vh"

module dssp_two_wire_slave (
	CLOCK,
	RST,
	SCL_IN,
	SDA_IN,
	SDA_OUT,
	SDA_OE,
	SELECT_N_PIN,
	REG_ADDR,
	REG_WR_DATA,
	REG_WR,
	REG_RD,
	REG_RD_DATA,
	TWO_WIRE_DISABLE
);
	input  wire       CLOCK;
	input  wire       RST;
	input  wire       SCL_IN;
	input  wire       SDA_IN;
	output wire       SDA_OUT;
	output reg        SDA_OE;
	input  wire       SELECT_N_PIN;
	output reg  [7:0] REG_ADDR;
	output reg  [7:0] REG_WR_DATA;
	output reg        REG_WR;
	output reg        REG_RD;
	input  wire [7:0] REG_RD_DATA;
	output reg        TWO_WIRE_DISABLE;

	// =========================================
	// states
	localparam ST_IDLE  = 6'b000001;
	localparam ST_DEV   = 6'b000010;
	localparam ST_REG   = 6'b000100;
	localparam ST_WDATA = 6'b001000;
	localparam ST_RDATA = 6'b010000;
	localparam ST_MACK  = 6'b100000;

	// =========================================
	// synchronisers
	reg [1:0] scl_s;
	reg [1:0] sda_s;
	reg [1:0] sel_s;
	reg       scl_d;
	reg       sda_d;

	always @(posedge CLOCK) begin
		scl_s <= {scl_s[0], SCL_IN};
		sda_s <= {sda_s[0], SDA_IN};
		sel_s <= {sel_s[0], SELECT_N_PIN};
		scl_d <= scl_s[1];
		sda_d <= sda_s[1];
	end

	wire scl      = scl_s[1];
	wire sda      = sda_s[1];
	// high select pin enables the two-wire side; disable bit gates it off
	wire tw_on    = sel_s[1] & ~TWO_WIRE_DISABLE;
	wire scl_rise = scl & ~scl_d;
	wire scl_fall = ~scl & scl_d;
	wire start_c  = tw_on & scl & scl_d & sda_d & ~sda;
	wire stop_c   = tw_on & scl & scl_d & ~sda_d & sda;

	// =========================================
	// address register
	wire [6:0] own_addr;
	reg        addr_wr;

	dssp_addr_reg u_addr (
		.clk     (CLOCK),
		.rst     (RST),
		.wr_en   (addr_wr),
		.wr_data (REG_WR_DATA[`DSSP_ADDR_MSB:0]),
		.addr    (own_addr)
	);

	// =========================================
	// byte engine
	reg [5:0] state;
	reg [7:0] shift;
	reg [2:0] bitcnt;
	reg       ack_phase;
	reg       sda_low;
	reg       wr_pend;

	// by stop the pointer has moved past the written byte, so decode the one before it
	wire [7:0] wr_target = REG_ADDR - 8'h01;

	assign SDA_OUT = 1'b0; // open drain: only ever pulls low, SCL never driven

	function addr_hit;
		input [7:0] b;
		input [6:0] a;
		addr_hit = (b[7:1] == a);
	endfunction

	always @(posedge CLOCK) begin
		REG_RD  <= 1'b0;
		REG_WR  <= 1'b0;
		addr_wr <= 1'b0;
		if (RST) begin
			state            <= ST_IDLE;
			shift            <= 8'h00;
			bitcnt           <= 3'h0;
			ack_phase        <= 1'b0;
			sda_low          <= 1'b0;
			SDA_OE           <= 1'b0;
			wr_pend          <= 1'b0;
			REG_ADDR         <= 8'h00;
			REG_WR_DATA      <= 8'h00;
			TWO_WIRE_DISABLE <= 1'b0;
		end else if (start_c) begin
			state     <= ST_DEV;
			bitcnt    <= 3'h0;
			ack_phase <= 1'b0;
			SDA_OE    <= 1'b0;
		end else if (stop_c || !tw_on) begin
			state     <= ST_IDLE;
			SDA_OE    <= 1'b0;
			ack_phase <= 1'b0;
			// a completed data byte takes effect at stop, or when select turns the port off
			if (wr_pend) begin
				REG_WR  <= 1'b1;
				wr_pend <= 1'b0;
				if (wr_target == `DSSP_REG_DEV_ADDR)
					addr_wr <= 1'b1;
				if (wr_target == `DSSP_REG_CONTROL)
					TWO_WIRE_DISABLE <= REG_WR_DATA[`DSSP_DIS_BIT];
			end
		end else if (scl_fall) begin
			// SDA_OE changes here, while clock is low; REG_* outputs move on clock rise or at stop
			if (ack_phase) begin
				ack_phase <= 1'b0;
				SDA_OE    <= 1'b0;
				if (state == ST_RDATA) begin
					shift  <= REG_RD_DATA;
					SDA_OE <= ~REG_RD_DATA[7];
				end
			end else if (sda_low) begin
				// the address ack of a read comes before the first data bit
				SDA_OE    <= 1'b1;
				ack_phase <= 1'b1;
				sda_low   <= 1'b0;
			end else if (state == ST_RDATA) begin
				SDA_OE <= ~shift[7];
			end else if (state == ST_MACK) begin
				SDA_OE <= 1'b0;
			end
		end else if (scl_rise && !ack_phase) begin
			case (state)
			ST_DEV, ST_REG, ST_WDATA: begin
				shift  <= {shift[6:0], sda};
				bitcnt <= bitcnt + 3'h1;
				if (bitcnt == `DSSP_BIT_LAST) begin
					sda_low <= 1'b1;
					if (state == ST_DEV) begin
						if (addr_hit({shift[6:0], sda}, own_addr)) begin
							if (sda == `DSSP_DIR_READ) begin
								state  <= ST_RDATA;
								REG_RD <= 1'b1;
							end else
								state <= ST_REG;
						end else begin
							state   <= ST_IDLE;
							sda_low <= 1'b0;
						end
					end else if (state == ST_REG) begin
						REG_ADDR <= {shift[6:0], sda};
						state    <= ST_WDATA;
					end else begin
						REG_WR_DATA <= {shift[6:0], sda};
						wr_pend     <= 1'b1;
						REG_ADDR    <= REG_ADDR + 8'h01;
						state       <= ST_WDATA;
					end
				end
			end
			ST_RDATA: begin
				shift  <= {shift[6:0], 1'b1};
				bitcnt <= bitcnt + 3'h1;
				if (bitcnt == `DSSP_BIT_LAST)
					state <= ST_MACK;
			end
			ST_MACK: begin
				// master ack asks for another byte; nack ends the read
				if (!sda) begin
					state     <= ST_RDATA;
					REG_ADDR  <= REG_ADDR + 8'h01;
					REG_RD    <= 1'b1;
					ack_phase <= 1'b1;
				end else
					state <= ST_IDLE;
			end
			ST_IDLE: begin
			end
			default: state <= ST_IDLE;
			endcase
		end
	end
endmodule // dssp_two_wire_slave

// file: verif/dssp_mst.sv
// Purpose: two-wire bus master model. Assumes: l is the wired data level. Notes: clock idles high
`timescale 1ns/100ps
module dssp_mst (
	input  wire c,
	input  wire l,
	output reg  scl = 1'b1,
	output reg  sda = 1'b1
);
	task e(input a, input b);
		begin
			scl <= a;
			sda <= b;
			repeat (2) @(posedge c);
		end
	endtask
	// data set up with the clock low, then moved to b with the clock high; b=0 start, b=1 stop
	task cnd(input b);
		begin
			e(1'b0, sda);
			e(1'b0, ~b);
			e(1'b1, ~b);
			e(1'b1, b);
		end
	endtask
	// x ends in the master's own ack bit, r in the sampled one
	task by(input [8:0] x, output [8:0] r);
		integer i;
		for (i = 8; i >= 0; i = i - 1) begin
			e(1'b0, sda);
			e(1'b0, x[i]);
			e(1'b1, x[i]);
			e(1'b1, x[i]);
			r[i] = l;
		end
	endtask
endmodule // dssp_mst

// file: verif/dssp_chk_checker.sv
// Purpose: port checks. Assumes: bound to the slave. Notes: one clock
`timescale 1ns/100ps
module dssp_chk (
	input wire CLOCK,
	input wire RST,
	input wire SCL_IN,
	input wire SDA_IN,
	input wire SDA_OUT,
	input wire SDA_OE,
	input wire SELECT_N_PIN,
	input wire REG_WR,
	input wire REG_RD,
	input wire TWO_WIRE_DISABLE
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RST);
	chk_rst_clear: assert property ($fell(RST) |-> !TWO_WIRE_DISABLE && !SDA_OE)
		else $error("reset state");
	chk_out_low: assert property (SDA_OUT == 1'b0)
		else $error("sda driven high");
	// ack edges stay in clock low, so the slave never forms a condition
	chk_oe_low: assert property ($changed(SDA_OE) |-> !SCL_IN)
		else $error("oe moved in clock high");
	chk_wr_one: assert property (REG_WR |=> !REG_WR)
		else $error("long write pulse");
	chk_rd_one: assert property (REG_RD |=> !REG_RD)
		else $error("long read pulse");
	chk_wr_stop: assert property (REG_WR |-> SCL_IN && SDA_IN)
		else $error("write outside stop");
	chk_sel_idle: assert property (!SELECT_N_PIN && !$past(SELECT_N_PIN, 4)
		|-> !$rose(SDA_OE))
		else $error("ack while deselected");
	chk_dis_idle: assert property (TWO_WIRE_DISABLE && $past(TWO_WIRE_DISABLE)
		|-> !$rose(SDA_OE))
		else $error("ack while disabled");
endmodule // dssp_chk
bind dssp_two_wire_slave dssp_chk u_dssp_chk (.CLOCK(CLOCK), .RST(RST), .SCL_IN(SCL_IN),
	.SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .SELECT_N_PIN(SELECT_N_PIN),
	.REG_WR(REG_WR), .REG_RD(REG_RD), .TWO_WIRE_DISABLE(TWO_WIRE_DISABLE));

// file: verif/tb.sv
// Purpose: slave bench. Assumes: register side returns address xor 5a. Notes: none
`timescale 1ns/100ps
module tb;
	reg        CLOCK = 1'b0;
	reg        RST = 1'b1;
	reg        SEL = 1'b1;
	reg  [7:0] rd = 8'h00;
	reg  [7:0] wa = 8'h00;
	reg  [7:0] wd = 8'h00;
	reg  [8:0] r;
	reg  [2:0] k;
	wire       scl, sdm, oe, wr, dis;
	wire [7:0] ra, wdt;
	wire       ln = sdm & ~oe;
	integer    err_count = 0;
	integer    cmp_count = 0;
	always #20 CLOCK = ~CLOCK;
	dssp_mst u_m (.c(CLOCK), .l(ln), .scl(scl), .sda(sdm));
	dssp_two_wire_slave u_dssp_two_wire_slave (.CLOCK(CLOCK), .RST(RST), .SCL_IN(scl),
		.SDA_IN(ln), .SDA_OUT(), .SDA_OE(oe), .SELECT_N_PIN(SEL), .REG_ADDR(ra),
		.REG_WR_DATA(wdt), .REG_WR(wr), .REG_RD(), .REG_RD_DATA(rd), .TWO_WIRE_DISABLE(dis));
	// the pointer has already moved on when the write pulse comes
	always @(posedge CLOCK) begin
		rd <= ra ^ 8'h5a;
		if (wr === 1'b1) begin
			wa <= ra - 8'h01;
			wd <= wdt;
		end
	end
	task ck(input [7:0] g, input [7:0] e);
		begin
			cmp_count = cmp_count + 1;
			if (g !== e) begin
				err_count = err_count + 1;
				$display("ERROR %0t got %h exp %h", $time, g, e);
			end
		end
	endtask
	task w3(input [6:0] a, input [7:0] g, input [7:0] d);
		begin
			u_m.cnd(1'b0);
			u_m.by({a, 2'b01}, r);
			k[2] = r[0];
			u_m.by({g, 1'b1}, r);
			k[1] = r[0];
			u_m.by({d, 1'b1}, r);
			k[0] = r[0];
			u_m.cnd(1'b1);
			repeat (8) @(posedge CLOCK);
		end
	endtask
	task t_wr;
		begin
			ck({7'h00, dis}, 8'h00);
			w3(7'h1c, 8'h0a, 8'h3c);
			ck({5'h00, k}, 8'h00);
			ck(wa, 8'h0a);
			ck(wd, 8'h3c);
			$display("write done");
		end
	endtask
	task t_rd;
		begin
			u_m.cnd(1'b0);
			u_m.by({7'h1c, 2'b01}, r);
			u_m.by({8'h06, 1'b1}, r);
			ck({7'h00, r[0]}, 8'h00);
			u_m.cnd(1'b0);
			u_m.by({7'h1c, 2'b11}, r);
			ck({7'h00, r[0]}, 8'h00);
			u_m.by({8'hff, 1'b0}, r);
			ck(r[8:1], 8'h5c);
			u_m.by({8'hff, 1'b1}, r);
			ck(r[8:1], 8'h5d);
			u_m.cnd(1'b1);
			$display("read done");
		end
	endtask
	task t_no;
		begin
			w3(7'h1d, 8'h0a, 8'h55);
			ck({5'h00, k}, 8'h07);
			@(posedge CLOCK);
			SEL <= 1'b0;
			w3(7'h1c, 8'h0a, 8'h66);
			ck({5'h00, k}, 8'h07);
			SEL <= 1'b1;
			ck(wd, 8'h3c);
			$display("refuse done");
		end
	endtask
	task t_adr;
		begin
			w3(7'h1c, 8'h0c, 8'h2a);
			w3(7'h1c, 8'h0a, 8'h11);
			ck({5'h00, k}, 8'h07);
			w3(7'h2a, 8'h02, 8'h01);
			ck({5'h00, k}, 8'h00);
			ck({7'h00, dis}, 8'h01);
			w3(7'h2a, 8'h0a, 8'h22);
			ck({5'h00, k}, 8'h07);
			RST <= 1'b1;
			repeat (2) @(posedge CLOCK);
			RST <= 1'b0;
			repeat (4) @(posedge CLOCK);
			ck({7'h00, dis}, 8'h00);
			// reset brings back the factory address
			w3(7'h1c, 8'h0a, 8'h44);
			ck({5'h00, k}, 8'h00);
			ck(wd, 8'h44);
			$display("address done");
		end
	endtask
	task results;
		begin
			$display("checks %0d errors %0d", cmp_count, err_count);
			if (err_count == 0 && cmp_count > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	initial begin
		repeat (12) @(posedge CLOCK);
		RST <= 1'b0;
		repeat (4) @(posedge CLOCK);
		t_wr;
		t_rd;
		t_no;
		t_adr;
		results;
	end
	initial begin
		#2000000;
		err_count = err_count + 1;
		results;
	end
endmodule // tb
